// file: shared/exc_pkg.sv
// Constants for the exception and interrupt vectoring unit.
// Assumes one core clock domain; no software-visible registers.
`default_nettype none
package exc_pkg;
  localparam int          NUM_SRC         = 16;
  localparam int          NUM_EXT         = 8;
  localparam logic [15:0] CODE_RESET      = 16'hFFF0;
  localparam logic [15:0] CODE_NMI        = 16'hFFD0;
  localparam logic [15:0] CODE_TRAP_HI    = 16'hFFB0;
  localparam logic [15:0] CODE_TRAP_LO    = 16'hFFA0;
  localparam logic [15:0] CODE_ADDR_TRAP  = 16'hFFC0;
  localparam logic [15:0] CODE_UNDEF_OP   = 16'hFF90;
  localparam logic [15:0] CODE_DIV_ZERO   = 16'hFF80;
  localparam logic [15:0] CODE_F_INVALID  = 16'hFF70;
  localparam logic [15:0] CODE_F_DIV_ZERO = 16'hFF68;
  localparam logic [15:0] CODE_F_OVERFLOW = 16'hFF64;
  localparam logic [15:0] CODE_F_RESERVED = 16'hFF60;
  localparam logic [15:0] CODE_MASK_BASE  = 16'hFE00;
  localparam logic [15:0] CODE_DOUBLE_VEC = 16'hFFD0;
  localparam logic [15:0] VEC_HIGH        = 16'hFFFF;
  localparam logic [15:0] VEC_FLOAT       = 16'hFF60;
  localparam logic [4:0]  LEVEL_IDLE      = 5'h1F;
  localparam logic [15:0] MASK_RESET      = 16'hFFFF;
  localparam logic [7:0]  GROUP_RESET     = 8'hE4;
  localparam logic [15:0] EDGE_RESET      = 16'hAAAA;
endpackage
`default_nettype wire

// file: core/interrupt_exception_vectoring.sv
// Exception and interrupt vectoring unit of the core.
// Assumes the pipeline presents faults as one-cycle pulses on i_clk_sys and
// holds i_take_ready high when it can start a handler.
// Overview of operation
// - Exceptions are served before pending interrupts.
// - Trap instructions and detected faults both start exception entry.
// - Sixteen request sources are accepted.
// - Maskable requests ranked by four programmable groups, nesting allowed.
// - Each maskable request has its own mask bit.
// - Valid edge of each external request is configurable.
// - Nested request accepted only when outranking the handler in service.
// - Float faults report distinct codes, sharing one handler vector.
// - Requests come from on-chip peripherals and external pins.
// - Entry other than reset saves return PC into normal or fatal saved-PC register.
// - Aborted long instruction saves its own PC for restart.
// - Double fault puts first code low and second code high.
// - Float underflow and precision loss are never raised.
`timescale 1ns/100ps
`default_nettype none
module interrupt_exception_vectoring (
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  input  wire logic [7:0]  i_ext_request,
  input  wire logic [7:0]  i_periph_request,
  input  wire logic        i_nmi,
  input  wire logic [15:0] i_edge_select,
  input  wire logic [15:0] i_request_mask,
  input  wire logic [7:0]  i_group_priority,
  input  wire logic [31:0] i_current_pc,
  input  wire logic [31:0] i_next_pc,
  input  wire logic        i_long_op_active,
  input  wire logic        i_trap_instr,
  input  wire logic [4:0]  i_trap_vector,
  input  wire logic        i_address_trap,
  input  wire logic        i_undefined_opcode_fault,
  input  wire logic        i_integer_divide_zero_fault,
  input  wire logic        i_float_invalid_op,
  input  wire logic        i_float_divide_zero,
  input  wire logic        i_float_overflow,
  input  wire logic        i_float_reserved_operand,
  input  wire logic        i_in_exception,
  input  wire logic        i_take_ready,
  input  wire logic        i_handler_return,
  output logic             o_take,
  output logic             o_fatal,
  output logic [15:0]      o_exception_code,
  output logic [31:0]      o_handler_address,
  output logic [31:0]      o_saved_pc_normal,
  output logic [31:0]      o_saved_pc_fatal,
  output logic [31:0]      o_exception_cause_register,
  output logic [4:0]       o_level_in_service
);

  typedef struct packed {
    logic [7:0]  ext_sync1;
    logic [7:0]  ext_sync2;
    logic [7:0]  ext_prev;
    logic        nmi_sync1;
    logic        nmi_sync2;
    logic        nmi_prev;
    logic        nmi_pend;
    logic        reset_pend;
    logic [15:0] pend;
    logic [4:0]  level;
    logic [4:0]  level_prev;
    logic        take;
    logic        fatal;
    logic [15:0] code;
    logic [31:0] handler;
    logic [31:0] pc_normal;
    logic [31:0] pc_fatal;
    logic [31:0] cause;
  } state_type;

  state_type st;
  state_type next_st;

  // Rank of a source: group priority in the high bits, place in group low.
  function automatic logic [4:0] rank_of(input logic [3:0] src,
                                         input logic [7:0] gp);
    logic [1:0] grp;
    grp = src[3:2];
    rank_of = {1'b0, gp[grp*2 +: 2], src[1:0]};
  endfunction

  function automatic logic edge_hit(input logic cur, input logic prev,
                                    input logic [1:0] sel);
    edge_hit = 1'b0;
    unique case (sel)
      2'b00:   edge_hit = ~cur & prev;
      2'b01:   edge_hit = cur & ~prev;
      2'b10:   edge_hit = cur ^ prev;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  logic [15:0] ext_edge;
  logic [15:0] raw_req;
  logic [15:0] live;
  logic        irq_found;
  logic [3:0]  irq_src;
  logic [4:0]  irq_rank;
  logic        exc_hit;
  logic [15:0] exc_code;
  logic [31:0] exc_pc;
  logic        exc_float;

  always_comb begin
    // External pins sit at even slots, peripherals at odd slots.
    ext_edge = '0;
    raw_req  = '0;
    for (int i = 0; i < exc_pkg::NUM_EXT; i++) begin
      ext_edge[2*i] = edge_hit(st.ext_sync2[i], st.ext_prev[i],
                               i_edge_select[2*i +: 2]);
      raw_req[2*i]   = ext_edge[2*i];
      raw_req[2*i+1] = i_periph_request[i];
    end
    live      = st.pend & ~i_request_mask;
    irq_found = 1'b0;
    irq_src   = 4'h0;
    irq_rank  = 5'h00;
    for (int i = 0; i < exc_pkg::NUM_SRC; i++) begin
      if (live[i] && (!irq_found ||
          rank_of(4'(i), i_group_priority) > irq_rank)) begin
        irq_found = 1'b1;
        irq_src   = 4'(i);
        irq_rank  = rank_of(4'(i), i_group_priority);
      end
    end
    // Fault priority follows the pipeline order; float codes are distinct.
    exc_hit   = 1'b1;
    exc_float = 1'b0;
    exc_pc    = i_current_pc;
    exc_code = exc_pkg::CODE_ADDR_TRAP;
    if (i_address_trap) begin
      exc_code = exc_pkg::CODE_ADDR_TRAP;
    end else if (i_undefined_opcode_fault) begin
      exc_code = exc_pkg::CODE_UNDEF_OP;
    end else if (i_integer_divide_zero_fault) begin
      exc_code = exc_pkg::CODE_DIV_ZERO;
    end else if (i_float_invalid_op) begin
      exc_float = 1'b1;
      exc_code  = exc_pkg::CODE_F_INVALID;
    end else if (i_float_divide_zero) begin
      exc_float = 1'b1;
      exc_code  = exc_pkg::CODE_F_DIV_ZERO;
    end else if (i_float_overflow) begin
      exc_float = 1'b1;
      exc_code  = exc_pkg::CODE_F_OVERFLOW;
    end else if (i_float_reserved_operand) begin
      exc_float = 1'b1;
      exc_code  = exc_pkg::CODE_F_RESERVED;
    end else if (i_trap_instr) begin
      exc_pc   = i_next_pc;
      exc_code = i_trap_vector[4] ? (exc_pkg::CODE_TRAP_HI |
                 {12'h000, i_trap_vector[3:0]}) :
                 (exc_pkg::CODE_TRAP_LO | {12'h000, i_trap_vector[3:0]});
    end else begin
      exc_hit = 1'b0;
    end
  end

  always_comb begin
    next_st            = st;
    next_st.take       = 1'b0;
    next_st.ext_sync1  = i_ext_request;
    next_st.ext_sync2  = st.ext_sync1;
    next_st.ext_prev   = st.ext_sync2;
    next_st.nmi_sync1  = i_nmi;
    next_st.nmi_sync2  = st.nmi_sync1;
    next_st.nmi_prev   = st.nmi_sync2;
    if (i_handler_return) begin
      next_st.level = st.level_prev;
    end
    if (st.reset_pend) begin
      // Reset entry saves nothing; the return PC is undefined.
      next_st.reset_pend = 1'b0;
      next_st.take       = 1'b1;
      next_st.code       = exc_pkg::CODE_RESET;
      next_st.handler    = {exc_pkg::VEC_HIGH, exc_pkg::CODE_RESET};
    end else if (exc_hit) begin
      next_st.take = 1'b1;
      if (i_in_exception) begin
        next_st.fatal    = 1'b1;
        next_st.cause    = {exc_code, st.code};
        next_st.code     = exc_code;
        next_st.handler  = {exc_pkg::VEC_HIGH, exc_pkg::CODE_DOUBLE_VEC};
        next_st.pc_fatal = exc_pc;
      end else begin
        next_st.cause     = {16'h0000, exc_code};
        next_st.code      = exc_code;
        // Two float codes are not multiples of 16, so the float faults need their own
        // shared vector instead of the rounded code.
        if (exc_float) begin
          next_st.handler = {exc_pkg::VEC_HIGH, exc_pkg::VEC_FLOAT};
        end else begin
          next_st.handler = {exc_pkg::VEC_HIGH, exc_code[15:4], 4'h0};
        end
        next_st.pc_normal = exc_pc;
      end
    end else if (st.nmi_pend && i_take_ready) begin
      next_st.nmi_pend  = 1'b0;
      next_st.take      = 1'b1;
      next_st.code      = exc_pkg::CODE_NMI;
      next_st.cause     = {16'h0000, exc_pkg::CODE_NMI};
      next_st.handler   = {exc_pkg::VEC_HIGH, exc_pkg::CODE_NMI};
      next_st.pc_fatal  = i_long_op_active ? i_current_pc : i_next_pc;
    end else if (irq_found && i_take_ready &&
        (st.level == exc_pkg::LEVEL_IDLE || irq_rank > st.level)) begin
      // only a strictly higher rank nests.
      next_st.take       = 1'b1;
      next_st.pend[irq_src] = 1'b0;
      next_st.level_prev = st.level;
      next_st.level      = irq_rank;
      next_st.code       = exc_pkg::CODE_MASK_BASE | {8'h00, irq_src, 4'h0};
      next_st.cause      = {16'h0000, next_st.code};
      next_st.handler    = {exc_pkg::VEC_HIGH, next_st.code};
      next_st.pc_normal  = i_long_op_active ? i_current_pc
                                            : i_next_pc;
    end
    // A new edge wins over the clear made by acceptance.
    next_st.pend = next_st.pend | raw_req;
    // Likewise a new non-maskable edge is never lost to the clear.
    if (st.nmi_sync2 && !st.nmi_prev) begin
      next_st.nmi_pend = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st            <= '0;
      st.reset_pend <= 1'b1;
      st.level      <= exc_pkg::LEVEL_IDLE;
      st.level_prev <= exc_pkg::LEVEL_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign o_take                     = st.take;
  assign o_fatal                    = st.fatal;
  assign o_exception_code           = st.code;
  assign o_handler_address          = st.handler;
  assign o_saved_pc_normal          = st.pc_normal;
  assign o_saved_pc_fatal           = st.pc_fatal;
  assign o_exception_cause_register = st.cause;
  assign o_level_in_service         = st.level;

endmodule // interrupt_exception_vectoring
`default_nettype wire

// file: testbench/exc_chk.sv
// Assertions on fault and double-fault entry of the vectoring unit.
// Bound to the unit; one clock, asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module exc_chk (
  input wire logic        i_clk_sys,
  input wire logic        i_arst_n,
  input wire logic [31:0] i_current_pc,
  input wire logic        i_address_trap,
  input wire logic        i_undefined_opcode_fault,
  input wire logic        i_integer_divide_zero_fault,
  input wire logic        i_float_invalid_op,
  input wire logic        i_in_exception,
  input wire logic        o_take,
  input wire logic        o_fatal,
  input wire logic [15:0] o_exception_code,
  input wire logic [31:0] o_handler_address,
  input wire logic [31:0] o_saved_pc_normal,
  input wire logic [31:0] o_exception_cause_register
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // Faults inside a handler become double faults, so they are kept apart.
  sequence s_addr; i_address_trap && !i_in_exception; endsequence
  sequence s_undef; i_undefined_opcode_fault && !i_address_trap
    && !i_in_exception; endsequence
  sequence s_div; i_integer_divide_zero_fault && !i_address_trap
    && !i_undefined_opcode_fault && !i_in_exception; endsequence
  sequence s_double; i_in_exception && i_address_trap; endsequence
  sequence s_finv; i_float_invalid_op && !i_address_trap
    && !i_undefined_opcode_fault && !i_integer_divide_zero_fault
    && !i_in_exception; endsequence
  addr_entry_a: assert property (s_addr |=> o_take
    && o_handler_address == 32'hFFFFFFC0) else $error("bad entry");
  addr_pc_a: assert property (s_addr |=>
    o_saved_pc_normal == $past(i_current_pc)) else $error("bad pc");
  addr_cause_a: assert property (s_addr |=>
    o_exception_cause_register == 32'h0000FFC0) else $error("bad cause");
  undef_code_a: assert property (s_undef |=>
    o_exception_code == 16'hFF90) else $error("bad undef code");
  undef_pc_a: assert property (s_undef |=>
    o_saved_pc_normal == $past(i_current_pc)) else $error("bad undef pc");
  div_code_a: assert property (s_div |=> o_take
    && o_exception_code == 16'hFF80) else $error("bad divide code");
  fatal_stick_a: assert property (o_fatal |=> o_fatal)
    else $error("fatal dropped");
  double_entry_a: assert property (s_double |=> o_fatal
    && o_handler_address == 32'hFFFFFFD0) else $error("bad double fault");
  float_vector_a: assert property (s_finv |=> o_take
    && o_exception_code == 16'hFF70
    && o_handler_address == 32'hFFFFFF60) else $error("bad float entry");
endmodule // exc_chk
bind interrupt_exception_vectoring exc_chk exc_chk_inst (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
  .i_current_pc(i_current_pc), .i_address_trap(i_address_trap),
  .i_undefined_opcode_fault(i_undefined_opcode_fault),
  .i_integer_divide_zero_fault(i_integer_divide_zero_fault),
  .i_float_invalid_op(i_float_invalid_op),
  .i_in_exception(i_in_exception), .o_take(o_take), .o_fatal(o_fatal),
  .o_exception_code(o_exception_code),
  .o_handler_address(o_handler_address),
  .o_saved_pc_normal(o_saved_pc_normal),
  .o_exception_cause_register(o_exception_cause_register));
`default_nettype wire

// file: testbench/pipeline_model.sv
// Pipeline stand-in: a steadily advancing PC and a stalling take-ready.
// Runs on the clock and reset of the unit it faces.
`timescale 1ns/100ps
`default_nettype none
module pipeline_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  output logic      [31:0] o_current_pc,
  output logic      [31:0] o_next_pc,
  output logic             o_take_ready
);
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) o_current_pc <= 32'h00000100;
    else o_current_pc <= o_current_pc + 32'h4;
  end
  assign o_next_pc = o_current_pc + 32'h4;
  // Two cycles in eight refuse a take, so late entries are exercised too.
  assign o_take_ready = o_current_pc[4] | o_current_pc[3];
endmodule // pipeline_model
`default_nettype wire

// file: testbench/test_interrupt_exception_vectoring.sv
// Random and corner-case bench of the vectoring unit and a pipeline model.
// The checker is bound to the unit; 25 MHz clock, reset held 16 cycles.
`timescale 1ns/100ps
`default_nettype none
module test_interrupt_exception_vectoring;
  localparam logic [15:0] TAB [7] = '{16'hFFC0, 16'hFF90, 16'hFF80,
    16'hFF70, 16'hFF68, 16'hFF64, 16'hFF60};
  logic        i_clk_sys = 1'b0, i_arst_n = 1'b0, i_nmi = 1'b0;
  logic        i_trap_instr = 1'b0, i_in_exception = 1'b0;
  logic        i_handler_return = 1'b0, i_long_op_active = 1'b0;
  logic        i_take_ready, o_take, o_fatal;
  logic [6:0]  flt = 7'h00;
  logic [7:0]  i_ext_request = 8'h00, i_periph_request = 8'h00;
  logic [7:0]  i_group_priority = exc_pkg::GROUP_RESET;
  logic [15:0] i_edge_select = exc_pkg::EDGE_RESET, o_exception_code, last;
  logic [15:0] i_request_mask = exc_pkg::MASK_RESET;
  logic [4:0]  i_trap_vector = 5'h00, o_level_in_service;
  logic [31:0] i_current_pc, i_next_pc, o_handler_address, prev_pc, r;
  logic [31:0] o_saved_pc_normal, o_saved_pc_fatal, o_exception_cause_register;
  int          fails = 0, n_compared = 0, seed = 32'h20C9;
  interrupt_exception_vectoring interrupt_exception_vectoring_inst (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_ext_request(i_ext_request), .i_periph_request(i_periph_request),
    .i_nmi(i_nmi), .i_edge_select(i_edge_select),
    .i_request_mask(i_request_mask), .i_group_priority(i_group_priority),
    .i_current_pc(i_current_pc), .i_next_pc(i_next_pc),
    .i_long_op_active(i_long_op_active), .i_trap_instr(i_trap_instr),
    .i_trap_vector(i_trap_vector), .i_address_trap(flt[0]),
    .i_undefined_opcode_fault(flt[1]),
    .i_integer_divide_zero_fault(flt[2]), .i_float_invalid_op(flt[3]),
    .i_float_divide_zero(flt[4]), .i_float_overflow(flt[5]),
    .i_float_reserved_operand(flt[6]), .i_in_exception(i_in_exception),
    .i_take_ready(i_take_ready), .i_handler_return(i_handler_return),
    .o_take(o_take), .o_fatal(o_fatal),
    .o_exception_code(o_exception_code),
    .o_handler_address(o_handler_address),
    .o_saved_pc_normal(o_saved_pc_normal),
    .o_saved_pc_fatal(o_saved_pc_fatal),
    .o_exception_cause_register(o_exception_cause_register),
    .o_level_in_service(o_level_in_service));
  pipeline_model pipeline_model_inst (.i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .o_current_pc(i_current_pc), .o_next_pc(i_next_pc),
    .o_take_ready(i_take_ready));
  always #20 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) prev_pc <= i_current_pc;
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) fails++;
    if (seen !== exp) $display("wrong value at %0t: %h expected %h",
      $time, seen, exp);
  endtask
  task automatic summarize;
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // The lowest set bit is the highest-ranked fault; a trap ranks below all.
  function automatic logic [15:0] exp_code(logic [6:0] f, logic [4:0] v);
    exp_code = {8'hFF, 3'h5, v};
    for (int i = 6; i >= 0; i--) if (f[i]) exp_code = TAB[i];
  endfunction
  task automatic pulse(logic [6:0] f, logic tr, logic [4:0] v);
    last = exp_code(f, v);
    @(posedge i_clk_sys);
    {flt, i_trap_instr, i_trap_vector} <= {f, tr, v};
    @(posedge i_clk_sys);
    {flt, i_trap_instr} <= 8'h00;
    #1;
    check(o_take, 1'b1);
    check(o_exception_code, last);
    check(o_exception_cause_register, {16'h0000, last});
    check(o_handler_address, f[2:0] == 0 && f != 0 ? 32'hFFFFFF60
      : {16'hFFFF, last[15:4], 4'h0});
    check(o_saved_pc_normal,
      f != 0 ? prev_pc : prev_pc + 32'h4);
  endtask
  task automatic wait_take(int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      i_handler_return <= 1'b0;
      #1;
      if (o_take === 1'b1) break;
    end
    check(o_take, 1'b1);
  endtask
  initial begin
    repeat (16) @(posedge i_clk_sys);
    check(o_level_in_service, 5'h1F);
    i_arst_n <= 1'b1;
    @(posedge i_clk_sys);
    #1;
    check(o_exception_code, 16'hFFF0);
    check(o_handler_address, 32'hFFFFFFF0);
    check(o_fatal, 1'b0);
    for (int i = 0; i < 7; i++) pulse(7'h01 << i, 1'b0, 5'h00);
    pulse(7'h00, 1'b1, 5'h1F);
    pulse(7'h00, 1'b1, 5'h03);
    repeat (40) begin
      r = $random(seed);
      pulse(r[6:0], r[7] || r[6:0] == 7'h00, r[12:8]);
    end
    @(posedge i_clk_sys);
    i_periph_request <= 8'h01;
    repeat (6) @(posedge i_clk_sys);
    #1;
    check(o_exception_code, last);
    check(o_take, 1'b0);
    @(posedge i_clk_sys);
    {i_request_mask, i_long_op_active} <= {16'hFFFD, 1'b1};
    wait_take(12);
    check(o_exception_code, 16'hFE10);
    check(o_saved_pc_normal, prev_pc);
    check(o_level_in_service !== 5'h1F, 1'b1);
    @(posedge i_clk_sys);
    {i_periph_request, i_long_op_active, i_handler_return} <= 10'h001;
    {i_request_mask, i_ext_request} <= {16'hFFFE, 8'h01};
    wait_take(12);
    check(o_exception_code, 16'hFE00);
    @(posedge i_clk_sys);
    {i_request_mask, i_nmi} <= {exc_pkg::MASK_RESET, 1'b1};
    wait_take(16);
    check(o_exception_code, 16'hFFD0);
    check(o_saved_pc_fatal, prev_pc + 32'h4);
    @(posedge i_clk_sys);
    {i_in_exception, flt} <= 8'h81;
    @(posedge i_clk_sys);
    flt <= 7'h00;
    #1;
    check(o_exception_cause_register, 32'hFFC0FFD0);
    check(o_fatal, 1'b1);
    check(o_saved_pc_fatal, prev_pc);
    check(o_handler_address, 32'hFFFFFFD0);
    // One more edge lets the checker see the double-fault consequent.
    @(posedge i_clk_sys);
    #1;
    check(o_fatal, 1'b1);
    summarize();
  end
  initial begin
    #(40 * 1000);
    fails++;
    summarize();
  end
endmodule // test_interrupt_exception_vectoring
`default_nettype wire
